// >>> hw/snos_pkg.sv
package snos_pkg;

  // ********************************************************************
  // opcode framing
  // ********************************************************************
  localparam int          OPC_W             = 8;
  localparam logic [3:0]  LAST_BIT          = 4'h7;
  localparam logic [2:0]  FIRST_OUT_BIT     = 3'h7;

  // ********************************************************************
  // opcodes
  // ********************************************************************
  localparam logic [7:0]  OPC_LATCH_SET     = 8'h06;
  localparam logic [7:0]  OPC_LATCH_CLEAR   = 8'h04;
  localparam logic [7:0]  OPC_STATUS_READ   = 8'h05;
  localparam logic [7:0]  OPC_STATUS_WRITE  = 8'h01;
  localparam logic [7:0]  OPC_ARRAY_READ    = 8'h03;
  localparam logic [7:0]  OPC_ARRAY_WRITE   = 8'h02;
  localparam logic [7:0]  OPC_FAST_READ     = 8'h0B;
  localparam logic [7:0]  OPC_DEEP_SLEEP    = 8'hBA;
  localparam logic [7:0]  OPC_HIBERNATE     = 8'hB9;
  localparam logic [7:0]  OPC_IDENT_READ    = 8'h9F;
  localparam logic [7:0]  OPC_UNIQUE_READ   = 8'h4C;
  localparam logic [7:0]  OPC_SERIAL_WRITE  = 8'hC2;
  localparam logic [7:0]  OPC_SERIAL_READ   = 8'hC3;
  localparam logic [7:0]  OPC_SECTOR_WRITE  = 8'h42;
  localparam logic [7:0]  OPC_SECTOR_READ   = 8'h4B;
  localparam logic [7:0]  OPC_FAST_SEC_READ = 8'h49;
  localparam logic [7:0]  OPC_RESERVED_A    = 8'hCE;
  localparam logic [7:0]  OPC_RESERVED_B    = 8'hCF;
  localparam logic [7:0]  OPC_RESERVED_C    = 8'hCC;

  // ********************************************************************
  // protect_status_byte layout
  // ********************************************************************
  localparam int          GUARD_EN_BIT      = 7;
  localparam int          SPARE_HI_BIT      = 6;
  localparam int          SPARE_LO_BIT      = 4;
  localparam int          BLOCK_HI_BIT      = 3;
  localparam int          BLOCK_LO_BIT      = 2;
  localparam int          LATCH_BIT         = 1;
  localparam int          ZERO_BIT          = 0;
  localparam int          NV_LO_BIT         = 2;
  localparam logic [7:0]  STATUS_RESET      = 8'h00;

  // ********************************************************************
  // link phase: the opcode and what follows it
  // ********************************************************************
  typedef enum logic [1:0] {
    SNOS_OPCODE = 2'b00,
    SNOS_WDATA  = 2'b01,
    SNOS_RDATA  = 2'b11,
    SNOS_PASS   = 2'b10
  } snos_phase_type;

endpackage

// >>> hw/snos_unit.sv
`timescale 1ns/1ps
module snos_unit
  import snos_pkg::*;
#(
  parameter logic [7:0] STATUS_INIT = snos_pkg::STATUS_RESET
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      ARST_N,
  input  wire logic                      SCK,
  input  wire logic                      CS_N,
  input  wire logic                      SI,
  input  wire logic                      WRITE_GUARD_N,
  input  wire logic                      WAKE_EVENT,
  output logic                           SO,
  output logic                           SO_OE,
  output logic [7:0]                     STATUS_BYTE,
  output logic                           WRITE_LATCH,
  output logic [snos_pkg::OPC_W-1:0]     CMD_CODE,
  output logic                           CMD_STROBE,
  output logic                           CMD_KNOWN
);
  import snos_pkg::*;

  // ********************************************************************
  // elaboration check
  // ********************************************************************
  // latch and fixed zero bits must power up clear
  if (STATUS_INIT[LATCH_BIT:ZERO_BIT] != 2'h0) begin : g_bad_init
    $error("STATUS_INIT must have bits 1 and 0 clear");
  end

  // shifter, counter and decode are built for byte-wide opcodes only
  if (OPC_W != 8) begin : g_bad_width
    $error("opcode width must be eight");
  end

  // the bit counter has to wrap to zero after the last opcode bit
  if (int'(LAST_BIT) != OPC_W - 1) begin : g_bad_last
    $error("last bit index must match the opcode width");
  end

  // ********************************************************************
  // link domain declarations
  // ********************************************************************
  logic                 link_rst_n;
  logic [3:0]           bit_cnt;
  logic [7:0]           shreg;
  snos_phase_type       phase;
  snos_phase_type       next_phase;
  logic [7:0]           next_shreg;
  logic [3:0]           next_bit_cnt;
  logic                 bit_done;
  logic                 op_fire;
  logic                 wr_fire;
  logic [7:0]           op_code;
  logic                 op_tgl;
  logic [7:0]           wr_data;
  logic                 wr_tgl;
  logic [7:0]           mir_meta;
  logic [7:0]           mir;
  logic [2:0]           out_idx;

  // ********************************************************************
  // core domain declarations
  // ********************************************************************
  logic [7:0]           status;
  logic [7:0]           next_status;
  logic [2:0]           op_sync;
  logic [2:0]           wr_sync;
  logic [1:0]           wp_sync;
  logic                 op_ev;
  logic                 wr_ev;
  logic                 hit_latch_set;
  logic                 hit_latch_clear;
  logic                 hit_status_read;
  logic                 hit_status_write;
  logic                 hit_array_read;
  logic                 hit_array_write;
  logic                 hit_fast_read;
  logic                 hit_deep_sleep;
  logic                 hit_hibernate;
  logic                 hit_ident_read;
  logic                 hit_unique_read;
  logic                 hit_serial_write;
  logic                 hit_serial_read;
  logic                 hit_sector_write;
  logic                 hit_sector_read;
  logic                 hit_fast_sec_read;
  logic                 known;
  logic                 guard_open;
  logic                 wr_take;
  logic                 latch_clr;
  logic                 latch_set;
  logic                 next_latch;
  logic [7:NV_LO_BIT]   next_nv;

  // ********************************************************************
  // link: opcode and data shifting
  // ********************************************************************
  // deselect kills the frame at once; a partial opcode never fires
  assign link_rst_n   = ARST_N & ~CS_N;
  assign next_shreg   = {shreg[6:0], SI};
  assign bit_done     = (bit_cnt == LAST_BIT);
  assign next_bit_cnt = bit_done ? 4'h0 : bit_cnt + 4'h1;
  assign op_fire      = (phase == SNOS_OPCODE) & bit_done;
  // only a whole data byte counts as a status write
  assign wr_fire      = (phase == SNOS_WDATA) & bit_done;

  always_comb begin
    next_phase = phase;
    unique case (phase)
      SNOS_OPCODE: begin
        if (bit_done) begin
          if (next_shreg == OPC_STATUS_WRITE) begin
            next_phase = SNOS_WDATA;
          end else if (next_shreg == OPC_STATUS_READ) begin
            next_phase = SNOS_RDATA;
          end else begin
            next_phase = SNOS_PASS;
          end
        end
      end
      SNOS_WDATA: begin
        if (bit_done) begin
          next_phase = SNOS_PASS;
        end
      end
      SNOS_RDATA: begin
        next_phase = SNOS_RDATA;
      end
      SNOS_PASS: begin
        next_phase = SNOS_PASS;
      end
    endcase
  end

  always_ff @(posedge SCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end else begin
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
    end
  end

  always_ff @(posedge SCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      phase <= SNOS_OPCODE;
    end else begin
      phase <= next_phase;
    end
  end

  // ********************************************************************
  // link: event capture, survives deselect
  // ********************************************************************
  // held words stay put until the next event, long after the core
  // has taken them through the toggle synchronisers
  always_ff @(posedge SCK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_code <= 8'h00;
      op_tgl  <= 1'b0;
    end else if (op_fire) begin
      op_code <= next_shreg;
      op_tgl  <= ~op_tgl;
    end
  end

  // only a whole data byte is handed over; a cut byte never toggles
  always_ff @(posedge SCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_data <= 8'h00;
      wr_tgl  <= 1'b0;
    end else if (wr_fire) begin
      wr_data <= next_shreg;
      wr_tgl  <= ~wr_tgl;
    end
  end

  // ********************************************************************
  // link: status mirror
  // ********************************************************************
  // the serial clock only runs inside frames, so the mirror settles
  // during the eight opcode edges; the byte is static while selected
  always_ff @(posedge SCK or negedge ARST_N) begin
    if (!ARST_N) begin
      mir_meta <= STATUS_INIT;
      mir      <= STATUS_INIT;
    end else begin
      mir_meta <= status;
      mir      <= mir_meta;
    end
  end

  // ********************************************************************
  // link: status read out on falling edges
  // ********************************************************************
  // the byte repeats for as long as the host keeps clocking
  always_ff @(negedge SCK or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_idx <= FIRST_OUT_BIT;
      SO      <= 1'b0;
      SO_OE   <= 1'b0;
    end else if (phase == SNOS_RDATA) begin
      out_idx <= out_idx - 3'h1;
      SO      <= mir[out_idx];
      SO_OE   <= 1'b1;
    end
  end

  // ********************************************************************
  // core: synchronisers
  // ********************************************************************
  // each toggle passes two flops before the edge detect reads it
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      op_sync <= 3'h0;
    end else begin
      op_sync <= {op_sync[1:0], op_tgl};
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wr_sync <= 3'h0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
    end
  end

  // guard pin is asynchronous to both clocks
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wp_sync <= 2'h0;
    end else begin
      wp_sync <= {wp_sync[0], WRITE_GUARD_N};
    end
  end

  assign op_ev = op_sync[2] ^ op_sync[1];
  assign wr_ev = wr_sync[2] ^ wr_sync[1];

  // ********************************************************************
  // core: opcode decode
  // ********************************************************************
  assign hit_latch_set     = (op_code == OPC_LATCH_SET);
  assign hit_latch_clear   = (op_code == OPC_LATCH_CLEAR);
  assign hit_status_read   = (op_code == OPC_STATUS_READ);
  assign hit_status_write  = (op_code == OPC_STATUS_WRITE);
  assign hit_array_read    = (op_code == OPC_ARRAY_READ);
  assign hit_array_write   = (op_code == OPC_ARRAY_WRITE);
  assign hit_fast_read     = (op_code == OPC_FAST_READ);
  assign hit_deep_sleep    = (op_code == OPC_DEEP_SLEEP);
  assign hit_hibernate     = (op_code == OPC_HIBERNATE);
  assign hit_ident_read    = (op_code == OPC_IDENT_READ);
  assign hit_unique_read   = (op_code == OPC_UNIQUE_READ);
  assign hit_serial_write  = (op_code == OPC_SERIAL_WRITE);
  assign hit_serial_read   = (op_code == OPC_SERIAL_READ);
  assign hit_sector_write  = (op_code == OPC_SECTOR_WRITE);
  assign hit_sector_read   = (op_code == OPC_SECTOR_READ);
  assign hit_fast_sec_read = (op_code == OPC_FAST_SEC_READ);
  // reserved codes fall out as unknown and do nothing here
  assign known = hit_latch_set     |
                 hit_latch_clear   |
                 hit_status_read   |
                 hit_status_write  |
                 hit_array_read    |
                 hit_array_write   |
                 hit_fast_read     |
                 hit_deep_sleep    |
                 hit_hibernate     |
                 hit_ident_read    |
                 hit_unique_read   |
                 hit_serial_write  |
                 hit_serial_read   |
                 hit_sector_write  |
                 hit_sector_read   |
                 hit_fast_sec_read;

  // ********************************************************************
  // core: status byte update
  // ********************************************************************
  // guard pin low with the guard enable set freezes status bits 7 to 2; the latch bit still moves
  assign guard_open = ~status[GUARD_EN_BIT] | wp_sync[1];
  assign wr_take    = wr_ev & status[LATCH_BIT] & guard_open;
  assign latch_clr  = (op_ev & hit_latch_clear) | WAKE_EVENT;
  assign latch_set  = op_ev & hit_latch_set;
  // write-type commands have no term here, so the latch stays set;
  // a set command landing with a wake event wins over the clear
  assign next_latch = latch_set ? 1'b1 :
                      latch_clr ? 1'b0 : status[LATCH_BIT];
  assign next_nv    = wr_take ? wr_data[7:NV_LO_BIT] :
                      status[7:NV_LO_BIT];
  // incoming bits 1 and 0 are dropped; bit 0 is a constant zero
  assign next_status = {next_nv, next_latch, 1'b0};

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status <= STATUS_INIT;
    end else begin
      status <= next_status;
    end
  end

  assign STATUS_BYTE = status;
  assign WRITE_LATCH = status[LATCH_BIT];

  // ********************************************************************
  // core: command report to the rest of the device
  // ********************************************************************
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD_STROBE <= 1'b0;
    end else begin
      CMD_STROBE <= op_ev;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      CMD_CODE  <= 8'h00;
      CMD_KNOWN <= 1'b0;
    end else if (op_ev) begin
      CMD_CODE  <= op_code;
      CMD_KNOWN <= known;
    end
  end

endmodule

// >>> bench/snos_unit_sva.sv
`timescale 1ns/1ps
module snos_unit_sva
  import snos_pkg::*;
(
  input wire logic       REF_CLK,
  input wire logic       ARST_N,
  input wire logic       WAKE_EVENT,
  input wire logic [7:0] STATUS_BYTE,
  input wire logic       WRITE_LATCH,
  input wire logic [7:0] CMD_CODE,
  input wire logic       CMD_STROBE,
  input wire logic       CMD_KNOWN
);
  // ****************************************
  // core-domain checks
  // ****************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  wire logic known_code;
  assign known_code = CMD_CODE inside {8'h06, 8'h04, 8'h05, 8'h01,
    8'h03, 8'h02, 8'h0B, 8'hBA, 8'hB9, 8'h9F, 8'h4C, 8'hC2, 8'hC3,
    8'h42, 8'h4B, 8'h49};

  property p_zero_bit;
    STATUS_BYTE[0] == 1'b0;
  endproperty
  a_zero_bit: assert property (p_zero_bit) else $error("bit 0 set");
  property p_mirror;
    WRITE_LATCH == STATUS_BYTE[1];
  endproperty
  a_mirror: assert property (p_mirror) else $error("latch mirror");
  property p_pulse;
    CMD_STROBE |=> !CMD_STROBE;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long strobe");
  property p_known;
    CMD_STROBE |-> CMD_KNOWN == known_code;
  endproperty
  a_known: assert property (p_known) else $error("bad decode");
  // a latch rise must come from the set command and nothing else
  property p_set;
    $rose(WRITE_LATCH) |-> CMD_STROBE && CMD_CODE == OPC_LATCH_SET;
  endproperty
  a_set: assert property (p_set) else $error("stray latch set");
  property p_clr;
    CMD_STROBE && CMD_CODE == OPC_LATCH_CLEAR |-> !WRITE_LATCH;
  endproperty
  a_clr: assert property (p_clr) else $error("latch not cleared");
  // a set command in the wake cycle wins and shows as a strobe
  property p_wake;
    WAKE_EVENT |=> !WRITE_LATCH ||
      (CMD_STROBE && CMD_CODE == OPC_LATCH_SET);
  endproperty
  a_wake: assert property (p_wake) else $error("wake kept latch");
  property p_set_wins;
    CMD_STROBE && CMD_CODE == OPC_LATCH_SET |-> WRITE_LATCH;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("no set");
  property p_quiet;
    $changed(STATUS_BYTE[7:2]) |-> $past(WRITE_LATCH);
  endproperty
  a_quiet: assert property (p_quiet) else $error("unlatched write");

  c_write: cover property ($changed(STATUS_BYTE[7:2]));
  c_wake: cover property (WAKE_EVENT ##1 !WRITE_LATCH);
  c_read: cover property (CMD_STROBE && CMD_CODE == OPC_STATUS_READ);
endmodule

// >>> bench/snos_host.sv
`timescale 1ns/1ps
module snos_host (
  output logic      SCK,
  output logic      CS_N,
  output logic      SI,
  input  wire logic SO,
  input  wire logic SO_OE
);
  // ****************************************
  // mode 0 master, clock still between frames
  // ****************************************
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b1;
  end
  // n bits of tx msb first; rx gathers bits 9..16
  task automatic frame(input logic [15:0] tx, input int n,
                       output logic [7:0] rx);
    rx = 8'h00;
    #3.3 CS_N = 1'b0;
    for (int i = 0; i < n; i++) begin
      SI = tx[15-i];
      #7.5 SCK = 1'b1;
      if (i >= 8) rx = {rx[6:0], SO_OE ? SO : 1'bx};
      #7.5 SCK = 1'b0;
    end
    #7.5 CS_N = 1'b1;
    // released line shows the inverse, not a stale value
    SI = ~SI;
    #60;
  endtask
endmodule

// >>> bench/test_spi_nvram_opcode_status_unit.sv
`timescale 1ns/1ps
module test_spi_nvram_opcode_status_unit;
  import snos_pkg::*;
  logic       ref_clk;
  logic       arst_n;
  logic       guard_n;
  logic       wake;
  wire logic  sck, cs_n, si, so, so_oe, latch, strobe, known;
  wire logic [7:0] status, code;
  int         fail_count = 0;
  int         check_count = 0;
  logic [8:0] exp_q[$];
  logic [7:0] rd;
  logic [7:0] lfsr = 8'h0E;
  logic [7:0] ops[16] = '{OPC_LATCH_SET, OPC_LATCH_CLEAR,
    OPC_STATUS_READ, OPC_STATUS_WRITE, OPC_ARRAY_READ, OPC_ARRAY_WRITE,
    OPC_FAST_READ, OPC_DEEP_SLEEP, OPC_HIBERNATE, OPC_IDENT_READ,
    OPC_UNIQUE_READ, OPC_SERIAL_WRITE, OPC_SERIAL_READ, OPC_SECTOR_WRITE,
    OPC_SECTOR_READ, OPC_FAST_SEC_READ};

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  snos_unit u_dut (.REF_CLK(ref_clk), .ARST_N(arst_n), .SCK(sck),
    .CS_N(cs_n), .SI(si), .WRITE_GUARD_N(guard_n), .WAKE_EVENT(wake),
    .SO(so), .SO_OE(so_oe), .STATUS_BYTE(status), .WRITE_LATCH(latch),
    .CMD_CODE(code), .CMD_STROBE(strobe), .CMD_KNOWN(known));
  snos_host u_host (.SCK(sck), .CS_N(cs_n), .SI(si), .SO(so),
    .SO_OE(so_oe));

  // ****************************************
  // checking
  // ****************************************
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] want);
    check_count++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // an unlisted strobe can never match 1FF; looked at mid-cycle
  always @(negedge ref_clk) begin
    if (strobe === 1'b1) begin
      if (exp_q.size() == 0)
        check({known, code}, 9'h1FF);
      else
        check({known, code}, exp_q.pop_front());
    end
  end
  // only defined opcodes are sent
  task automatic cmd(input logic [7:0] op, input logic [7:0] d,
                     input int n);
    if (n >= 8)
      exp_q.push_back({1'b1, op});
    u_host.frame({op, d}, n, rd);
  endtask
  task automatic status_is(input logic [7:0] want);
    check({1'b0, status}, {1'b0, want});
    check({8'h00, latch}, {8'h00, want[1]});
    cmd(OPC_STATUS_READ, 8'h00, 16);
    check({1'b0, rd}, {1'b0, want});
  endtask
  task automatic pin_guard(input logic v);
    @(posedge ref_clk);
    guard_n <= v;
    repeat (4) @(posedge ref_clk);
  endtask

  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    arst_n = 1'b0;
    guard_n = 1'b1;
    wake = 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    status_is(8'h00);
    for (int i = 0; i < 16; i++)
      cmd(ops[i], 8'h00, 8);
    cmd(OPC_STATUS_WRITE, 8'hFF, 16);
    status_is(8'h00);
    cmd(OPC_LATCH_SET, 8'h00, 8);
    for (int k = 0; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      cmd(OPC_STATUS_WRITE, lfsr, 16);
      status_is((lfsr & 8'hFC) | 8'h02);
    end
    cmd(OPC_STATUS_WRITE, 8'h80, 16);
    pin_guard(1'b0);
    cmd(OPC_STATUS_WRITE, 8'h7C, 16);
    status_is(8'h82);
    pin_guard(1'b1);
    cmd(OPC_STATUS_WRITE, 8'h00, 16);
    cmd(OPC_SERIAL_WRITE, 8'h00, 8);
    cmd(OPC_SECTOR_WRITE, 8'h00, 8);
    status_is(8'h02);
    cmd(OPC_LATCH_CLEAR, 8'h00, 5);
    status_is(8'h02);
    @(posedge ref_clk);
    wake <= 1'b1;
    @(posedge ref_clk);
    wake <= 1'b0;
    repeat (2) @(posedge ref_clk);
    status_is(8'h00);
    cmd(OPC_LATCH_SET, 8'h00, 8);
    cmd(OPC_LATCH_CLEAR, 8'h00, 8);
    status_is(8'h00);
    cmd(OPC_LATCH_SET, 8'h00, 8);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    status_is(8'h00);
    cmd(OPC_LATCH_SET, 8'h00, 8);
    status_is(8'h02);
    give_verdict();
  end
endmodule

bind snos_unit snos_unit_sva u_sva (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .WAKE_EVENT(WAKE_EVENT), .STATUS_BYTE(STATUS_BYTE),
  .WRITE_LATCH(WRITE_LATCH), .CMD_CODE(CMD_CODE),
  .CMD_STROBE(CMD_STROBE), .CMD_KNOWN(CMD_KNOWN));
